// ===== core/rea_defines.vh
// Constants for the remote event annunciator
`ifndef REA_DEFINES_VH
`define REA_DEFINES_VH
// Event type codes
`define REA_EV_TROUBLE   3'h0
`define REA_EV_ALARM     3'h1
`define REA_EV_SEQUENCE  3'h2
`define REA_EV_VERIFY    3'h3
`define REA_EV_SUPERV    3'h4
// Buzzer modes
`define REA_BUZ_OFF      2'h0
`define REA_BUZ_PULSED   2'h1
`define REA_BUZ_CONT     2'h2
// Group and node ranges
`define REA_GROUP_MASTER 5'h00
`define REA_NODE_MIN     6'h01
`define REA_NODE_MAX     6'h20
// Lower line text limit in characters
`define REA_TEXT_MAX     6'h28
// Timing
`define REA_CLK_KHZ      20000
`define REA_BLINK_MS     250
`define REA_BLINK_CYC    (`REA_BLINK_MS * `REA_CLK_KHZ)
// Reset values
`define REA_RELAY_RST    1'b1
`endif

// ===== core/rea_annunciator.v
// Remote event annunciator: acceptance, indicators, display, log, forwarding
`timescale 1ns/1ps
`include "rea_defines.vh"
module rea_annunciator #(
	parameter        NOUT      = 8,
	parameter [31:0] BLINK_CYC = `REA_BLINK_CYC
) (
	input  wire            clk_i,
	input  wire            sys_rst_i,
	input  wire            ce_i,
	input  wire [4:0]      cfg_group_i,
	input  wire            cfg_group_set_i,
	input  wire            nlc_fitted_i,
	input  wire            serial_fitted_i,
	input  wire            rdm_fitted_i,
	input  wire            ann_fitted_i,
	input  wire            clr_i,
	input  wire            evt_valid_i,
	input  wire [2:0]      evt_type_i,
	input  wire            evt_local_i,
	input  wire            evt_timer_own_i,
	input  wire [4:0]      evt_group_i,
	input  wire [5:0]      evt_node_i,
	input  wire [7:0]      evt_addr_i,
	input  wire [1:0]      evt_state_i,
	input  wire [3:0]      evt_dev_type_i,
	input  wire [3:0]      evt_trbl_code_i,
	input  wire [7:0]      evt_text_id_i,
	input  wire [7:0]      evt_text_len_i,
	input  wire [NOUT-1:0] out_point_i,
	input  wire [NOUT-1:0] out_group_i,
	input  wire [NOUT-1:0] out_general_i,
	output reg             trbl_led_o,
	output reg             alarm_led_o,
	output reg             sup_led_o,
	output reg  [1:0]      buz_mode_o,
	output reg             buzzer_o,
	output reg             trbl_relay_o,
	output reg             disp_upd_o,
	output reg             disp_local_o,
	output reg  [2:0]      up_type_o,
	output reg  [5:0]      up_node_o,
	output reg  [7:0]      up_addr_o,
	output reg  [1:0]      up_state_o,
	output reg  [3:0]      up_dev_type_o,
	output reg  [3:0]      up_trbl_code_o,
	output reg  [7:0]      lo_text_id_o,
	output reg  [5:0]      lo_text_len_o,
	output reg             timer_show_o,
	output reg             log_we_o,
	output reg  [2:0]      log_type_o,
	output reg  [5:0]      log_node_o,
	output reg  [7:0]      log_addr_o,
	output reg             rdm_send_o,
	output reg             ann_send_o,
	output reg             nlc_send_o,
	output reg             serial_send_o,
	output reg  [NOUT-1:0] out_on_o
);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function is_indicated;
		input [2:0] t;
		begin
			is_indicated = (t == `REA_EV_TROUBLE) || (t == `REA_EV_ALARM) ||
				(t == `REA_EV_SUPERV);
		end
	endfunction

	function [5:0] clip_len;
		input [7:0] len;
		begin
			if (len > {2'b00, `REA_TEXT_MAX})
				clip_len = `REA_TEXT_MAX;
			else
				clip_len = len[5:0];
		end
	endfunction

	// ------------------------------------------------------------
	// Acceptance
	// ------------------------------------------------------------
	// Remote events need a valid origin node; local ones skip that check
	wire global_mode = ~cfg_group_set_i;
	wire is_master   = cfg_group_set_i && (cfg_group_i == `REA_GROUP_MASTER);
	wire same_group  = cfg_group_set_i && (evt_group_i == cfg_group_i);
	wire node_ok     = (evt_node_i >= `REA_NODE_MIN) && (evt_node_i <= `REA_NODE_MAX);
	wire type_ok     = (evt_type_i <= `REA_EV_SUPERV);
	wire accept      = evt_valid_i && type_ok && (evt_local_i || node_ok) &&
		(is_master || evt_local_i || same_group || global_mode);
	wire acc_ind     = accept && is_indicated(evt_type_i);
	wire ev_trbl     = accept && (evt_type_i == `REA_EV_TROUBLE);
	wire ev_alarm    = accept && (evt_type_i == `REA_EV_ALARM);
	wire ev_sup      = accept && (evt_type_i == `REA_EV_SUPERV);

	// ------------------------------------------------------------
	// Active event flags
	// ------------------------------------------------------------
	reg        trbl_act_r;
	reg        alarm_act_r;
	reg        sup_act_r;
	reg        pulse_act_r;
	reg        trbl_act_nxt;
	reg        alarm_act_nxt;
	reg        sup_act_nxt;
	reg        pulse_act_nxt;

	// New events win over a clear in the same cycle
	always @* begin
		trbl_act_nxt  = ev_trbl | (trbl_act_r & ~clr_i);
		alarm_act_nxt = ev_alarm | (alarm_act_r & ~clr_i);
		sup_act_nxt   = ev_sup | (sup_act_r & ~clr_i);
		pulse_act_nxt = (accept & ~ev_alarm) | (pulse_act_r & ~clr_i);
	end

	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			trbl_act_r  <= 1'b0;
			alarm_act_r <= 1'b0;
			sup_act_r   <= 1'b0;
			pulse_act_r <= 1'b0;
		end else if (ce_i) begin
			trbl_act_r  <= trbl_act_nxt;
			alarm_act_r <= alarm_act_nxt;
			sup_act_r   <= sup_act_nxt;
			pulse_act_r <= pulse_act_nxt;
		end
	end

	// ------------------------------------------------------------
	// Blink phase shared by flashing indicators and pulsed buzzer
	// ------------------------------------------------------------
	reg        phase_r;
	reg [31:0] blink_cnt_r;

	wire       blink_wrap = (blink_cnt_r >= BLINK_CYC - 32'h0000_0001);

	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			phase_r     <= 1'b0;
			blink_cnt_r <= 32'h0000_0000;
		end else if (ce_i) begin
			if (blink_wrap) begin
				blink_cnt_r <= 32'h0000_0000;
				phase_r     <= ~phase_r;
			end else begin
				blink_cnt_r <= blink_cnt_r + 32'h0000_0001;
			end
		end
	end

	// ------------------------------------------------------------
	// Indicators, buzzer, relay
	// ------------------------------------------------------------
	reg [1:0] buz_mode_nxt;
	reg       buzzer_nxt;

	// Alarm holds the buzzer steady even while pulsed events are active
	always @* begin
		buz_mode_nxt = `REA_BUZ_OFF;
		buzzer_nxt   = 1'b0;
		if (alarm_act_r) begin
			buz_mode_nxt = `REA_BUZ_CONT;
			buzzer_nxt   = 1'b1;
		end else if (pulse_act_r) begin
			buz_mode_nxt = `REA_BUZ_PULSED;
			buzzer_nxt   = phase_r;
		end
	end

	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			trbl_led_o   <= 1'b0;
			alarm_led_o  <= 1'b0;
			sup_led_o    <= 1'b0;
			buz_mode_o   <= `REA_BUZ_OFF;
			buzzer_o     <= 1'b0;
			trbl_relay_o <= `REA_RELAY_RST;
		end else if (ce_i) begin
			trbl_led_o   <= trbl_act_r & phase_r;
			alarm_led_o  <= alarm_act_r & phase_r;
			sup_led_o    <= sup_act_r & phase_r;
			// Relay rests energized; an active trouble drops it
			trbl_relay_o <= ~trbl_act_r;
			buz_mode_o   <= buz_mode_nxt;
			buzzer_o     <= buzzer_nxt;
		end
	end

	// ------------------------------------------------------------
	// Display lines
	// ------------------------------------------------------------
	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			disp_upd_o     <= 1'b0;
			disp_local_o   <= 1'b0;
			up_type_o      <= 3'h0;
			up_node_o      <= 6'h00;
			up_addr_o      <= 8'h00;
			up_state_o     <= 2'h0;
			up_dev_type_o  <= 4'h0;
			up_trbl_code_o <= 4'h0;
			lo_text_id_o   <= 8'h00;
			lo_text_len_o  <= 6'h00;
			timer_show_o   <= 1'b0;
		end else if (ce_i) begin
			disp_upd_o <= accept;
			if (accept) begin
				disp_local_o  <= evt_local_i;
				up_type_o     <= evt_type_i;
				up_node_o     <= evt_node_i;
				up_addr_o     <= evt_addr_i;
				up_state_o    <= evt_state_i;
				up_dev_type_o <= evt_dev_type_i;
				if (ev_trbl && !evt_local_i)
					up_trbl_code_o <= evt_trbl_code_i;
				else
					up_trbl_code_o <= 4'h0;
				lo_text_id_o  <= evt_text_id_i;
				lo_text_len_o <= clip_len(evt_text_len_i);
				// Countdown only on the unit owning the detector report
				if ((evt_type_i == `REA_EV_SEQUENCE) || (evt_type_i == `REA_EV_VERIFY))
					timer_show_o <= evt_local_i & evt_timer_own_i;
				else
					timer_show_o <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Log and message forwarding
	// ------------------------------------------------------------
	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			log_we_o      <= 1'b0;
			log_type_o    <= 3'h0;
			log_node_o    <= 6'h00;
			log_addr_o    <= 8'h00;
			rdm_send_o    <= 1'b0;
			ann_send_o    <= 1'b0;
			nlc_send_o    <= 1'b0;
			serial_send_o <= 1'b0;
		end else if (ce_i) begin
			log_we_o      <= accept;
			rdm_send_o    <= accept & rdm_fitted_i;
			ann_send_o    <= acc_ind & ann_fitted_i;
			nlc_send_o    <= accept & nlc_fitted_i;
			serial_send_o <= accept & serial_fitted_i;
			if (accept) begin
				log_type_o <= evt_type_i;
				log_node_o <= evt_node_i;
				log_addr_o <= evt_addr_i;
			end
		end
	end

	// ------------------------------------------------------------
	// Output activation
	// ------------------------------------------------------------
	// Only outputs tied to a new trouble, alarm or supervisory event switch on; others keep state unless clr_i is high in that cycle
	wire [NOUT-1:0] assoc = out_point_i | out_group_i | out_general_i;
	reg  [NOUT-1:0] out_on_nxt;

	always @* begin
		out_on_nxt = out_on_o;
		if (acc_ind)
			out_on_nxt = assoc | (out_on_o & {NOUT{~clr_i}});
		else if (clr_i)
			out_on_nxt = {NOUT{1'b0}};
	end

	always @(posedge clk_i) begin
		if (sys_rst_i)
			out_on_o <= {NOUT{1'b0}};
		else if (ce_i)
			out_on_o <= out_on_nxt;
	end

endmodule // rea_annunciator

// ===== tb/rea_annunciator_props.sv
// Assertions for the remote event annunciator
`timescale 1ns/1ps
`include "rea_defines.vh"
module rea_annunciator_props #(parameter NOUT = 8) (
	input wire logic clk_i, sys_rst_i, ce_i, cfg_group_set_i, clr_i, evt_valid_i,
	input wire logic evt_local_i, nlc_fitted_i, serial_fitted_i, trbl_relay_o, buzzer_o,
	input wire logic disp_upd_o, disp_local_o, timer_show_o, log_we_o, nlc_send_o,
	input wire logic serial_send_o,
	input wire logic [4:0] cfg_group_i, evt_group_i,
	input wire logic [2:0] evt_type_i, up_type_o,
	input wire logic [5:0] evt_node_i, up_node_o, lo_text_len_o,
	input wire logic [7:0] evt_addr_i, up_addr_o, evt_text_len_i,
	input wire logic [1:0] buz_mode_o,
	input wire logic [NOUT-1:0] out_point_i, out_group_i, out_general_i, out_on_o
);
	wire node_ok = evt_node_i >= `REA_NODE_MIN && evt_node_i <= `REA_NODE_MAX;
	wire grp_ok = !cfg_group_set_i || cfg_group_i == `REA_GROUP_MASTER
		|| evt_group_i == cfg_group_i;
	wire acc = ce_i && evt_valid_i && evt_type_i <= `REA_EV_SUPERV
		&& (evt_local_i || grp_ok && node_ok);
	wire act = evt_type_i inside {`REA_EV_TROUBLE, `REA_EV_ALARM, `REA_EV_SUPERV};
	wire [NOUT-1:0] msk = out_point_i | out_group_i | out_general_i;
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	chk_accept_shown: assert property (acc |=> disp_upd_o && log_we_o)
		else $error("accepted event not shown");
	chk_reject_quiet: assert property (!acc |=> !disp_upd_o && !nlc_send_o)
		else $error("refused event produced output");
	chk_trbl_relay: assert property (acc && !evt_type_i ##1 ce_i |=> !trbl_relay_o)
		else $error("relay stayed energized");
	chk_alarm_cont: assert property (acc && evt_type_i == `REA_EV_ALARM ##1 ce_i
		|=> buz_mode_o == `REA_BUZ_CONT && buzzer_o) else $error("buzzer not continuous");
	chk_pulse_mode: assert property (acc && evt_type_i != `REA_EV_ALARM && !disp_upd_o
		&& buz_mode_o == `REA_BUZ_OFF ##1 ce_i |=> buz_mode_o == `REA_BUZ_PULSED)
		else $error("buzzer not pulsed");
	chk_timer_hide: assert property (acc && !evt_local_i |=> !timer_show_o)
		else $error("remote countdown shown");
	chk_text_clip: assert property (acc |=> lo_text_len_o == ($past(evt_text_len_i) >
		`REA_TEXT_MAX ? `REA_TEXT_MAX : $past(evt_text_len_i[5:0])))
		else $error("text length wrong");
	chk_upper_line: assert property (acc |=> up_node_o == $past(evt_node_i)
		&& up_addr_o == $past(evt_addr_i) && up_type_o == $past(evt_type_i)
		&& disp_local_o == $past(evt_local_i)) else $error("upper line wrong");
	chk_net_send: assert property (acc |=> nlc_send_o == $past(nlc_fitted_i)
		&& serial_send_o == $past(serial_fitted_i)) else $error("network send wrong");
	chk_outputs_on: assert property (acc && act && !clr_i
		|=> out_on_o == ($past(out_on_o) | $past(msk))) else $error("outputs wrong");
endmodule // rea_annunciator_props
bind rea_annunciator rea_annunciator_props #(.NOUT(NOUT)) rea_annunciator_props_i (.*);

// ===== tb/rea_peer_model.sv
// Peer control unit sending events over the panel network
`timescale 1ns/1ps
module rea_peer_model (
	input  wire logic        clk_i,
	input  wire logic        go_i,
	input  wire logic [49:0] ev_i,
	output logic             vld_o = 1'b0,
	output logic      [49:0] bus_o = '0
);
	// Fields scrambled outside the strobe
	always @(posedge clk_i) begin
		vld_o <= go_i;
		bus_o <= go_i ? ev_i : ~bus_o;
	end
endmodule // rea_peer_model

// ===== tb/rea_annunciator_tb.sv
// Self-checking bench for the remote event annunciator
`timescale 1ns/1ps
`include "rea_defines.vh"
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin miscompares++; \
	$display("[FAIL] %0t mismatch", $time); end end
module rea_annunciator_tb;
	logic clk_i = 0, sys_rst_i = 1, clr_i = 0, go = 0, set = 0, pul = 0, vld;
	logic [3:0] fit = '0;
	logic [4:0] grp = '0;
	logic [23:0] msk = '0;
	logic [49:0] ev = '0, bus;
	logic [7:0] exp_out = '0;
	logic [2:0] flg = '0, seen;
	int miscompares = 0, comparisons = 0;
	wire [7:0] out_on, up_addr;
	wire [3:0] snd, up_code;
	wire [2:0] led, up_type;
	wire [1:0] buz;
	wire [5:0] up_node, lo_len;
	wire relay, upd, loc_o, tshow, bzr, lwe;
	wire [1:0] up_state;
	wire [3:0] up_dev;
	wire [7:0] up_txt, log_addr;
	wire [2:0] log_type;
	wire [5:0] log_node;
	logic ce = 1;
	logic [1:0] bzs;
	rea_peer_model rea_peer_model_i (.clk_i(clk_i), .go_i(go), .ev_i(ev), .vld_o(vld), .bus_o(bus));
	rea_annunciator #(.BLINK_CYC(4)) rea_annunciator_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
		.ce_i(ce), .cfg_group_i(grp), .cfg_group_set_i(set), .nlc_fitted_i(fit[0]),
		.serial_fitted_i(fit[1]), .rdm_fitted_i(fit[2]), .ann_fitted_i(fit[3]), .clr_i(clr_i),
		.evt_valid_i(vld), .evt_type_i(bus[49:47]), .evt_local_i(bus[46]),
		.evt_timer_own_i(bus[45]), .evt_group_i(bus[44:40]), .evt_node_i(bus[39:34]),
		.evt_addr_i(bus[33:26]), .evt_state_i(bus[25:24]), .evt_dev_type_i(bus[23:20]),
		.evt_trbl_code_i(bus[19:16]), .evt_text_id_i(bus[15:8]), .evt_text_len_i(bus[7:0]),
		.out_point_i(msk[7:0]), .out_group_i(msk[15:8]), .out_general_i(msk[23:16]),
		.trbl_led_o(led[0]), .alarm_led_o(led[1]), .sup_led_o(led[2]), .buz_mode_o(buz),
		.buzzer_o(bzr), .trbl_relay_o(relay), .disp_upd_o(upd), .disp_local_o(loc_o),
		.up_type_o(up_type), .up_node_o(up_node), .up_addr_o(up_addr), .up_state_o(up_state),
		.up_dev_type_o(up_dev), .up_trbl_code_o(up_code), .lo_text_id_o(up_txt),
		.lo_text_len_o(lo_len), .timer_show_o(tshow), .log_we_o(lwe), .log_type_o(log_type),
		.log_node_o(log_node), .log_addr_o(log_addr),
		.rdm_send_o(snd[2]), .ann_send_o(snd[3]), .nlc_send_o(snd[0]),
		.serial_send_o(snd[1]), .out_on_o(out_on));
	initial forever #25 clk_i = ~clk_i;
	function automatic logic acc(input logic [49:0] e);
		return e[49:47] <= `REA_EV_SUPERV && (e[46] || e[39:34] >= `REA_NODE_MIN
			&& e[39:34] <= `REA_NODE_MAX && (!set || grp == `REA_GROUP_MASTER
			|| e[44:40] == grp));
	endfunction
	function automatic logic [49:0] mk(input [2:0] t, input l, o, input [4:0] g,
		input [5:0] n, input [7:0] len);
		return {t, l, o, g, n, 26'h2b3_c5a1, len};
	endfunction
	task automatic run_ev(input logic [49:0] e);
		logic a;
		logic [2:0] t;
		a = acc(e) && ce;
		t = e[49:47];
		ev = e;
		go = 1;
		@(posedge clk_i) #1 go = 0;
		@(posedge clk_i) #1;
		if (a && t inside {0, 1, 4}) begin
			exp_out |= msk[7:0] | msk[15:8] | msk[23:16];
			flg |= {t == 4, t == 1, t == 0};
		end
		pul |= a && t != 1;
		`CHK(upd, a)
		`CHK(snd, a ? {fit[3] & (t != 2 && t != 3), fit[2:0]} : 4'h0)
		`CHK(out_on, exp_out)
		if (a) begin
			`CHK({up_node, up_type, loc_o, up_addr}, {e[39:34], t, e[46], e[33:26]})
			`CHK(up_code, !e[46] && t == 0 ? e[19:16] : 4'h0)
			`CHK(lo_len, e[7:0] > 8'h28 ? `REA_TEXT_MAX : e[5:0])
			`CHK(tshow, e[46] & e[45] & (t == 2 || t == 3))
			`CHK({up_state, up_dev, up_txt}, {e[25:20], e[15:8]})
			`CHK({log_type, log_node, log_addr}, {t, e[39:34], e[33:26]})
		end
		`CHK(lwe, a)
		ce = 1;
		@(posedge clk_i) #1;
		`CHK(relay, !flg[0])
		`CHK(buz, flg[1] ? `REA_BUZ_CONT : pul ? `REA_BUZ_PULSED : `REA_BUZ_OFF)
		{seen, bzs} = '0;
		repeat (10) @(posedge clk_i) #1 begin
			seen |= led;
			bzs |= {bzr, !bzr};
		end
		`CHK(seen, flg)
		`CHK(bzs, flg[1] ? 2'b10 : pul ? 2'b11 : 2'b01)
	endtask
	task automatic clear();
		clr_i = 1;
		@(posedge clk_i) #1 clr_i = 0;
		repeat (2) @(posedge clk_i) #1;
		{exp_out, flg, pul} = '0;
		`CHK({relay, buz, out_on}, {1'b1, 2'h0, 8'h00})
	endtask
	task automatic give_verdict();
		if (miscompares == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		#500_000;
		miscompares++;
		give_verdict();
	end
	initial begin
		void'($urandom(32'h019a));
		repeat (4) @(posedge clk_i);
		#1 sys_rst_i = 0;
		{set, grp, fit, msk} = {1'b1, 5'h03, 4'hf, 24'h81_4201};
		run_ev(mk(1, 0, 0, 3, 6'h20, 8'h29));
		run_ev(mk(0, 0, 0, 3, 6'h01, 8'h28));
		run_ev(mk(4, 0, 0, 4, 6'h05, 8'hff));
		run_ev(mk(2, 0, 0, 3, 6'h00, 8'h00));
		run_ev(mk(2, 0, 0, 3, 6'h21, 8'h00));
		run_ev(mk(5, 1, 0, 3, 6'h05, 8'h00));
		run_ev(mk(3, 1, 1, 7, 6'h00, 8'h10));
		ce = 0;
		run_ev(mk(1, 0, 0, 3, 6'h05, 8'h01));
		clear();
		grp = 5'h00;
		run_ev(mk(4, 0, 0, 9, 6'h07, 8'h05));
		set = 0;
		run_ev(mk(2, 0, 1, 17, 6'h11, 8'h27));
		for (int i = 0; i < 60; i++) begin
			{set, grp, fit, msk} = 34'({$urandom, $urandom});
			ev = 50'({$urandom, $urandom});
			ev[49:47] = 3'($urandom_range(4));
			ev[39:34] = 6'($urandom_range(32, 1));
			if ($urandom_range(1))
				ev[44:40] = grp;
			run_ev(ev);
			if (i % 8 == 7)
				clear();
		end
		give_verdict();
	end
endmodule // rea_annunciator_tb
